//--- design/stc_pkg.sv
// Constants and types for the scan trigger control port
package stc_pkg;
    localparam int CLK_HZ           = 100_000_000;
    localparam int MS_TIME          = 1;
    localparam int MS_CYCLES        = CLK_HZ / 1000 * MS_TIME;
    localparam int OPEN_SETTLE_MS   = 5;
    localparam int CLOSE_SETTLE_MS  = 5;
    localparam int PULSE_MIN_MS     = 1;
    localparam int PULSE_MAX_MS     = 100;
    localparam int DELAY_MAX_MS     = 9999;
    localparam int PULSE_RESET_MS   = 5;
    localparam int DELAY_RESET_MS   = 0;
    localparam int MS_W             = 14;
    localparam int CH_W             = 8;
    localparam logic [MS_W-1:0] MS_ONE  = 14'h0001;
    localparam logic [MS_W-1:0] MS_ZERO = 14'h0000;
    localparam logic [CH_W-1:0] CH_ZERO = 8'h00;
    localparam logic [CH_W-1:0] CH_ONE  = 8'h01;

    typedef enum logic [6:0] {
        ST_IDLE    = 7'b0000001,
        ST_OPEN    = 7'b0000010,
        ST_OSETTLE = 7'b0000100,
        ST_CLOSE   = 7'b0001000,
        ST_CSETTLE = 7'b0010000,
        ST_DELAY   = 7'b0100000,
        ST_CLOSED  = 7'b1000000
    } stc_state_type;

    typedef struct packed {
        logic [MS_W-1:0] delay_ms;
        logic [MS_W-1:0] pulse_ms;
    } stc_cfg_type;

    typedef struct packed {
        logic            relay_on;
        logic [CH_W-1:0] channel;
        logic            closed_out;
        logic            scanning;
    } stc_status_type;
endpackage : stc_pkg

//--- design/stc_in_sync.sv
// Input synchroniser with polarity and edge detection
`timescale 1ns/1ps
`default_nettype none
module stc_in_sync (
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic pin_in,
    input  wire logic sink_mode,
    output logic      rise_pulse
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic lvl_reg;
    logic lvl_next;
    logic act_lvl;

    assign act_lvl  = s2_reg ^ sink_mode;
    assign lvl_next = (s2_reg == s3_reg) ? act_lvl : lvl_reg;

    always_ff @(posedge ref_clk)
    begin
        s1_reg <= pin_in;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (srst)
        begin
            lvl_reg    <= 1'b0;
            rise_pulse <= 1'b0;
        end
        else
        begin
            lvl_reg    <= lvl_next;
            rise_pulse <= lvl_next & ~lvl_reg;
        end
    end

    chk_edge_single: assert property (@(posedge ref_clk) disable iff (srst)
        rise_pulse |=> !rise_pulse)
        else $error("edge pulse longer than one cycle");
endmodule : stc_in_sync
`default_nettype wire

//--- design/stc_scan_ctrl.sv
// Scan sequencer behind the isolated external control port
`timescale 1ns/1ps
`default_nettype none
module stc_scan_ctrl #(
    parameter int              CH_COUNT  = 8,
    parameter int              MS_CYC    = stc_pkg::MS_CYCLES,
    parameter logic [7:0]      LIST_LEN  = 8'h08
) (
    input  wire logic                      ref_clk,
    input  wire logic                      srst,
    input  wire logic                      scan_step_pin,
    input  wire logic                      scan_abort_pin,
    input  wire logic                      sink_mode,
    input  wire stc_pkg::stc_cfg_type      cfg_in,
    input  wire logic                      cfg_load,
    output logic                           channel_closed_out,
    output logic [CH_COUNT-1:0]            relay_drive,
    output stc_pkg::stc_status_type        status
);
    localparam int TICK_W = $clog2(MS_CYC + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MS_CYC - 1);
    localparam logic [TICK_W-1:0] TICK_ZERO = '0;

    logic                       step_evt;
    logic                       abort_evt;
    stc_pkg::stc_state_type     state_reg;
    stc_pkg::stc_state_type     state_next;
    logic [TICK_W-1:0]          tick_reg;
    logic                       ms_tick;
    logic [stc_pkg::MS_W-1:0]   ms_left_reg;
    logic [stc_pkg::MS_W-1:0]   ms_left_next;
    logic [stc_pkg::MS_W-1:0]   delay_reg;
    logic [stc_pkg::MS_W-1:0]   pulse_reg;
    logic [stc_pkg::MS_W-1:0]   pulse_fit;
    logic [stc_pkg::MS_W-1:0]   delay_fit;
    logic [stc_pkg::CH_W-1:0]   chan_reg;
    logic [stc_pkg::CH_W-1:0]   chan_next;
    logic                       relay_on_reg;
    logic                       relay_on_next;
    logic                       closed_reg;
    logic                       closed_next;
    logic                       timer_done;
    logic                       in_switch;
    logic                       step_take;
    logic [CH_COUNT-1:0]        relay_next;
    logic                       timer_load;

    stc_in_sync u_step (
        .ref_clk    (ref_clk),
        .srst       (srst),
        .pin_in     (scan_step_pin),
        .sink_mode  (sink_mode),
        .rise_pulse (step_evt)
    );

    stc_in_sync u_abort (
        .ref_clk    (ref_clk),
        .srst       (srst),
        .pin_in     (scan_abort_pin),
        .sink_mode  (sink_mode),
        .rise_pulse (abort_evt)
    );

    // Millisecond timebase
    assign ms_tick    = (tick_reg == TICK_LAST);
    assign timer_done = (ms_left_reg == stc_pkg::MS_ZERO);
    assign timer_load = (state_next != state_reg) &&
                        (state_next == stc_pkg::ST_OSETTLE ||
                         state_next == stc_pkg::ST_CSETTLE ||
                         state_next == stc_pkg::ST_DELAY ||
                         state_next == stc_pkg::ST_CLOSED);

    assign pulse_fit = (cfg_in.pulse_ms < stc_pkg::MS_W'(stc_pkg::PULSE_MIN_MS)) ?
                       stc_pkg::MS_W'(stc_pkg::PULSE_MIN_MS) :
                       (cfg_in.pulse_ms > stc_pkg::MS_W'(stc_pkg::PULSE_MAX_MS)) ?
                       stc_pkg::MS_W'(stc_pkg::PULSE_MAX_MS) : cfg_in.pulse_ms;
    assign delay_fit = (cfg_in.delay_ms > stc_pkg::MS_W'(stc_pkg::DELAY_MAX_MS)) ?
                       stc_pkg::MS_W'(stc_pkg::DELAY_MAX_MS) : cfg_in.delay_ms;

    assign in_switch = ~(state_reg == stc_pkg::ST_IDLE || state_reg == stc_pkg::ST_CLOSED);
    assign step_take = step_evt & ~in_switch & ~abort_evt;

    always_comb
    begin
        state_next    = state_reg;
        ms_left_next  = ms_left_reg;
        chan_next     = chan_reg;
        relay_on_next = relay_on_reg;
        closed_next   = closed_reg;
        if (ms_tick && !timer_done)
        begin
            ms_left_next = ms_left_reg - stc_pkg::MS_ONE;
        end
        if (abort_evt)
        begin
            state_next    = stc_pkg::ST_IDLE;
            relay_on_next = 1'b0;
            closed_next   = 1'b0;
            chan_next     = stc_pkg::CH_ZERO;
        end
        else
        begin
            case (state_reg)
                stc_pkg::ST_IDLE:
                begin
                    if (step_take)
                    begin
                        chan_next  = stc_pkg::CH_ZERO;
                        state_next = stc_pkg::ST_CLOSE;
                    end
                end
                stc_pkg::ST_CLOSED:
                begin
                    if (closed_reg && timer_done)
                    begin
                        closed_next = 1'b0;
                    end
                    if (step_take)
                    begin
                        state_next = stc_pkg::ST_OPEN;
                    end
                end
                stc_pkg::ST_OPEN:
                begin
                    relay_on_next = 1'b0;
                    closed_next   = 1'b0;
                    chan_next     = (chan_reg + stc_pkg::CH_ONE >= LIST_LEN) ?
                                    stc_pkg::CH_ZERO : chan_reg + stc_pkg::CH_ONE;
                    ms_left_next  = stc_pkg::MS_W'(stc_pkg::OPEN_SETTLE_MS);
                    state_next    = stc_pkg::ST_OSETTLE;
                end
                stc_pkg::ST_OSETTLE:
                begin
                    if (timer_done)
                    begin
                        state_next = stc_pkg::ST_CLOSE;
                    end
                end
                stc_pkg::ST_CLOSE:
                begin
                    relay_on_next = 1'b1;
                    ms_left_next  = stc_pkg::MS_W'(stc_pkg::CLOSE_SETTLE_MS);
                    state_next    = stc_pkg::ST_CSETTLE;
                end
                stc_pkg::ST_CSETTLE:
                begin
                    if (timer_done)
                    begin
                        ms_left_next = delay_reg;
                        state_next   = stc_pkg::ST_DELAY;
                    end
                end
                stc_pkg::ST_DELAY:
                begin
                    if (timer_done)
                    begin
                        closed_next  = 1'b1;
                        ms_left_next = pulse_reg;
                        state_next   = stc_pkg::ST_CLOSED;
                    end
                end
                default:
                begin
                    state_next    = stc_pkg::ST_IDLE;
                    relay_on_next = 1'b0;
                    closed_next   = 1'b0;
                end
            endcase
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < CH_COUNT; gi++)
        begin : g_relay
            assign relay_next[gi] = relay_on_next &&
                                    (chan_next == stc_pkg::CH_W'(gi));
        end
    endgenerate

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            tick_reg <= TICK_ZERO;
        end
        else
        begin
            tick_reg <= (ms_tick || timer_load) ? TICK_ZERO : tick_reg + TICK_W'(1);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            delay_reg <= stc_pkg::MS_W'(stc_pkg::DELAY_RESET_MS);
            pulse_reg <= stc_pkg::MS_W'(stc_pkg::PULSE_RESET_MS);
        end
        else if (cfg_load)
        begin
            delay_reg <= delay_fit;
            pulse_reg <= pulse_fit;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state_reg          <= stc_pkg::ST_IDLE;
            ms_left_reg        <= stc_pkg::MS_ZERO;
            chan_reg           <= stc_pkg::CH_ZERO;
            relay_on_reg       <= 1'b0;
            closed_reg         <= 1'b0;
            channel_closed_out <= 1'b0;
            relay_drive        <= '0;
            status             <= '0;
        end
        else
        begin
            state_reg          <= state_next;
            ms_left_reg        <= ms_left_next;
            chan_reg           <= chan_next;
            relay_on_reg       <= relay_on_next;
            closed_reg         <= closed_next;
            channel_closed_out <= closed_next;
            relay_drive        <= relay_next;
            status.relay_on    <= relay_on_next;
            status.channel     <= chan_next;
            status.closed_out  <= closed_next;
            status.scanning    <= (state_next != stc_pkg::ST_IDLE);
        end
    end

    chk_abort_opens: assert property (@(posedge ref_clk) disable iff (srst)
        abort_evt |=> (relay_drive == '0) && !channel_closed_out)
        else $error("abort did not open relays");
    chk_abort_restart: assert property (@(posedge ref_clk) disable iff (srst)
        abort_evt |=> (status.channel == stc_pkg::CH_ZERO) && !status.scanning)
        else $error("abort did not reset scan position");
    chk_idle_start: assert property (@(posedge ref_clk) disable iff (srst)
        (state_reg == stc_pkg::ST_IDLE) && step_take |=> state_reg == stc_pkg::ST_CLOSE)
        else $error("idle step did not start scan");
    chk_busy_ignore: assert property (@(posedge ref_clk) disable iff (srst)
        in_switch && !abort_evt && (state_reg != stc_pkg::ST_DELAY) |=>
        $stable(chan_reg) || ($past(state_reg) == stc_pkg::ST_OPEN))
        else $error("step taken during switch");
    chk_step_ignored: assert property (@(posedge ref_clk) disable iff (srst)
        step_evt && in_switch && !abort_evt |=> state_reg != stc_pkg::ST_OPEN)
        else $error("step accepted during switch");
    chk_open_clears: assert property (@(posedge ref_clk) disable iff (srst)
        state_reg == stc_pkg::ST_OPEN |=> !channel_closed_out && (relay_drive == '0))
        else $error("pulse held while relay open");
    chk_pulse_relay: assert property (@(posedge ref_clk) disable iff (srst)
        channel_closed_out |-> relay_drive != '0)
        else $error("pulse without closed relay");
    chk_pulse_load: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(channel_closed_out) |-> ms_left_reg == pulse_reg)
        else $error("closed pulse width not loaded");
    chk_pulse_width: assert property (@(posedge ref_clk) disable iff (srst)
        pulse_reg >= stc_pkg::MS_W'(stc_pkg::PULSE_MIN_MS) &&
        pulse_reg <= stc_pkg::MS_W'(stc_pkg::PULSE_MAX_MS))
        else $error("pulse width out of range");
    chk_open_settle: assert property (@(posedge ref_clk) disable iff (srst)
        state_reg == stc_pkg::ST_OPEN && !abort_evt |=>
        state_reg == stc_pkg::ST_OSETTLE &&
        ms_left_reg == stc_pkg::MS_W'(stc_pkg::OPEN_SETTLE_MS))
        else $error("open settle not loaded");
    chk_close_settle: assert property (@(posedge ref_clk) disable iff (srst)
        state_reg == stc_pkg::ST_CLOSE && !abort_evt |=>
        ms_left_reg == stc_pkg::MS_W'(stc_pkg::CLOSE_SETTLE_MS) && relay_drive != '0)
        else $error("close settle not loaded");
    chk_settle_order: assert property (@(posedge ref_clk) disable iff (srst)
        state_reg == stc_pkg::ST_OSETTLE && timer_done && !abort_evt |=>
        state_reg == stc_pkg::ST_CLOSE)
        else $error("close did not follow open settle");
    chk_delay_range: assert property (@(posedge ref_clk) disable iff (srst)
        delay_reg <= stc_pkg::MS_W'(stc_pkg::DELAY_MAX_MS))
        else $error("channel delay out of range");

    cov_start: cover property (@(posedge ref_clk) disable iff (srst)
        state_reg == stc_pkg::ST_IDLE ##1 state_reg == stc_pkg::ST_CLOSE);
    cov_pulse: cover property (@(posedge ref_clk) disable iff (srst)
        $rose(channel_closed_out));
    cov_advance: cover property (@(posedge ref_clk) disable iff (srst)
        channel_closed_out ##1 state_reg == stc_pkg::ST_OPEN);
    cov_abort: cover property (@(posedge ref_clk) disable iff (srst)
        abort_evt && status.scanning);
endmodule : stc_scan_ctrl
`default_nettype wire

//--- sim/stc_ctrl_model.sv
// Behavioural controller that drives the step and abort pins
`timescale 1ns/1ps
`default_nettype none
module stc_ctrl_model #(
    parameter int HOLD_CYC = 10
) (
    input  wire logic ref_clk,
    input  wire logic sink_mode,
    output var logic  scan_step_pin,
    output var logic  scan_abort_pin
);
    initial
    begin
        scan_step_pin  = sink_mode;
        scan_abort_pin = sink_mode;
    end

    task automatic pulse_step();
        @(negedge ref_clk);
        scan_step_pin = ~sink_mode;
        repeat (HOLD_CYC) @(negedge ref_clk);
        scan_step_pin = sink_mode;
        repeat (HOLD_CYC) @(negedge ref_clk);
    endtask : pulse_step

    task automatic pulse_abort();
        @(negedge ref_clk);
        scan_abort_pin = ~sink_mode;
        repeat (HOLD_CYC) @(negedge ref_clk);
        scan_abort_pin = sink_mode;
        repeat (HOLD_CYC) @(negedge ref_clk);
    endtask : pulse_abort
endmodule : stc_ctrl_model
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the scan sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int MSC   = 10;
    localparam int LIMIT = 40000;
    typedef struct {int ch; int lat; int w; int t;} stc_note_type;

    logic                    ref_clk;
    logic                    srst;
    logic                    sink_mode;
    logic                    step_pin;
    logic                    abort_pin;
    logic                    cfg_load;
    logic                    closed;
    logic [7:0]              relay;
    stc_pkg::stc_cfg_type    cfg;
    stc_pkg::stc_status_type status;
    stc_note_type            notes[$];
    int                      error_cnt;
    int                      n_checks;
    int                      cyc;
    int                      d;

    stc_scan_ctrl #(.CH_COUNT(8), .MS_CYC(MSC), .LIST_LEN(8'h08)) dut (
        .ref_clk(ref_clk), .srst(srst), .scan_step_pin(step_pin),
        .scan_abort_pin(abort_pin), .sink_mode(sink_mode), .cfg_in(cfg),
        .cfg_load(cfg_load), .channel_closed_out(closed), .relay_drive(relay),
        .status(status));

    stc_ctrl_model #(.HOLD_CYC(MSC)) ctl (
        .ref_clk(ref_clk), .sink_mode(sink_mode),
        .scan_step_pin(step_pin), .scan_abort_pin(abort_pin));

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic check(logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        if (error_cnt == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc >= LIMIT)
        begin
            error_cnt++;
            results();
        end
    end

    task automatic wait_lvl(logic v, int lim);
        int i;
        for (i = 0; i < lim && closed !== v; i++) @(negedge ref_clk);
        check(closed, v);
    endtask : wait_lvl

    task automatic go(int ch, int lat_ms, int w);
        notes.push_back('{ch, lat_ms * MSC, w, cyc});
        ctl.pulse_step();
    endtask : go

    task automatic load(int dly, int pw);
        @(negedge ref_clk);
        cfg      = '{delay_ms: 14'(dly), pulse_ms: 14'(pw)};
        cfg_load = 1'b1;
        @(negedge ref_clk);
        cfg_load = 1'b0;
    endtask : load

    task automatic do_reset(logic sm);
        srst      = 1'b1;
        sink_mode = sm;
        ctl.scan_step_pin  = sm;
        ctl.scan_abort_pin = sm;
        repeat (12) @(negedge ref_clk);
        srst = 1'b0;
    endtask : do_reset

    task automatic idle_chk();
        repeat (8) @(negedge ref_clk);
        check({relay, closed, status.scanning}, 10'h000);
    endtask : idle_chk

    // Each rising closed pulse is matched with the oldest note
    initial
    begin : mon
        stc_note_type n;
        int           t0;
        forever
        begin
            @(posedge closed);
            t0 = cyc;
            @(negedge ref_clk);
            if (notes.size() == 0)
                check(1, 0);
            else
            begin
                n = notes.pop_front();
                check(relay, 8'h01 << n.ch);
                check(status.channel, n.ch);
                check({status.relay_on, status.closed_out, status.scanning}, 3'h7);
                check(t0 - n.t >= n.lat && t0 - n.t <= n.lat + 40, 1);
                @(negedge closed);
                if (n.w != 0)
                    check(cyc - t0 >= (n.w - 1) * MSC && cyc - t0 <= (n.w + 1) * MSC, 1);
            end
        end
    end

    initial
    begin
        srst = 1'b1;
        sink_mode = 1'b0;
        cfg = '0;
        cfg_load = 1'b0;
        error_cnt = 0;
        n_checks = 0;
        cyc = 0;
        void'($urandom(70));
        do_reset(1'b0);
        check({relay, closed}, 9'h000);
        go(0, 5, 5);
        wait_lvl(1'b1, 200);
        wait_lvl(1'b0, 100);
        go(1, 10, 5);
        ctl.pulse_step();
        wait_lvl(1'b1, 200);
        wait_lvl(1'b0, 100);
        d = 1 + int'($urandom % 3);
        load(d, 0);
        for (int c = 2; c <= 8; c++)
        begin
            go(c % 8, 10 + d, 1);
            wait_lvl(1'b1, 300);
            wait_lvl(1'b0, 40);
        end
        load(0, 200);
        go(1, 10, 0);
        wait_lvl(1'b1, 200);
        repeat (20) @(negedge ref_clk);
        go(2, 10, 0);
        repeat (4) @(negedge ref_clk);
        check({closed, relay}, 9'h000);
        repeat (30) @(negedge ref_clk);
        check(relay, 8'h00);
        wait_lvl(1'b1, 200);
        ctl.pulse_abort();
        idle_chk();
        load(0, 2);
        go(0, 5, 2);
        wait_lvl(1'b1, 200);
        wait_lvl(1'b0, 40);
        go(1, 10, 2);
        wait_lvl(1'b1, 200);
        wait_lvl(1'b0, 40);
        ctl.pulse_step();
        repeat (10) @(negedge ref_clk);
        ctl.pulse_abort();
        idle_chk();
        go(0, 5, 2);
        wait_lvl(1'b1, 200);
        wait_lvl(1'b0, 40);
        do_reset(1'b1);
        check({relay, closed}, 9'h000);
        go(0, 5, 5);
        wait_lvl(1'b1, 200);
        wait_lvl(1'b0, 100);
        check(notes.size(), 0);
        results();
    end
endmodule : tb_top
`default_nettype wire
